//--- inc/byte_counter_consts.vh
// Constants for the eight-bit transmit counter: register offsets, field positions,
// reset values and prescaler codes.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef BYTE_COUNTER_CONSTS_VH
`define BYTE_COUNTER_CONSTS_VH

// Register offsets on the plain register port
`define OFS_COUNTER8_CONTROL 8'h00
`define OFS_SHARED_TIMER_CONFIG 8'h01
`define OFS_LOW_LEVEL_HOLD 8'h04
`define OFS_HIGH_LEVEL_HOLD 8'h05
`define OFS_WIDE_COUNTER_LOW_HOLD 8'h06
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h09
`define OFS_COUNT_VALUE 8'h0a

// Fields of counter8_control
`define CTL_ENABLE_BIT 7
`define CTL_SINGLE_PASS_BIT 6
`define CTL_TIMEOUT_BIT 5
`define CTL_PRESCALE_HI 4
`define CTL_PRESCALE_LO 3
`define CTL_CAPTURE_IE_BIT 2
`define CTL_TIMEOUT_IE_BIT 1

// Field of shared_timer_config
`define CFG_INIT_LEVEL_BIT 1

// Fields of the interrupt status and mask registers
`define IRQ_TIMEOUT_BIT 0

// Reset values
`define RST_CONTROL 8'h00
`define RST_CONFIG 8'h00
`define RST_HOLD 8'h00
`define RST_IRQ_MASK 8'h00

// Prescaler select codes
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV2 2'h1
`define PRESCALE_DIV4 2'h2
`define PRESCALE_DIV8 2'h3

// Count value that marks the last step before zero
`define COUNT_LAST 8'h01

`endif

//--- rtl/count_prescaler.v
// Prescaler: turns the system clock into a one-cycle count tick at 1/1, 1/2, 1/4 or 1/8.
// Assumes a synchronous select from the same clock domain; restarts while run_i is low.
`timescale 1ns/1ps
`include "byte_counter_consts.vh"

module count_prescaler #(
  parameter DIV_WIDTH = 3
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Control
  input wire run_i,
  input wire [1:0] prescale_select_i,
  // Tick
  output reg tick_o
);

  reg [DIV_WIDTH-1:0] div_q;
  reg tick_d;

  ////////////////////////////////////////////////////////////////////////////
  // Tick decode: a tick each time the low bits of the divider roll over
  always @* begin
    case (prescale_select_i)
      `PRESCALE_DIV1: tick_d = run_i;
      `PRESCALE_DIV2: tick_d = run_i & (div_q[0] == 1'b1);
      `PRESCALE_DIV4: tick_d = run_i & (div_q[1:0] == 2'h3);
      default: tick_d = run_i & (div_q[2:0] == 3'h7);
    endcase
  end

  // Free divider, held at zero when stopped so the first period is always full
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      div_q <= {DIV_WIDTH{1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= tick_d;
      if (run_i) begin
        div_q <= div_q + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      end else begin
        div_q <= {DIV_WIDTH{1'b0}};
      end
    end
  end

endmodule // count_prescaler

//--- rtl/eight_bit_transmit_counter.v
// Eight-bit down counter in transmit mode with two level hold registers and a toggling output.
// Assumes a register master on the same clock; reads answer one cycle after the strobe.
//
// Functional notes
// [RULE_01] Enabling the counter drives the toggle output to the initial level from the shared config.
// [RULE_02] At enable the count loads from the low hold when the initial level is 0, else from the high hold.
// [RULE_03] In single pass the counter runs to zero, halts, toggles the output once and sets the timeout flag.
// [RULE_04] A single-pass timeout interrupts only when the timeout interrupt enable bit is set.
// [RULE_05] In modulo-N the first terminal count toggles without interrupt and reloads by the new level.
// [RULE_06] In modulo-N the second terminal count toggles, sets the timeout flag and interrupts if enabled.
// [RULE_07] After each full modulo-N cycle the reload is again chosen by the level, until disabled.
// [RULE_08] Hold registers take writes at any time and act only at the next reload from them.
// [RULE_09] Software must not write a hold register in the cycle the counter reloads from it.
// [RULE_10] Software must never program an initial count of 1.
// [RULE_11] An initial count of zero wraps through FFH and FEH, giving a full 256-step count.
// [RULE_12] Control bit 2 enables the capture interrupt when 1 and resets to 0.
// [RULE_13] Control bits 4 and 3 pick the count rate as the clock over 1, 2, 4 or 8, resetting to 00.
// [RULE_14] Control bit 5 reads the timeout flag; writing 1 clears it, 0 does nothing, reset clears it.
// [RULE_15] Control bit 7 runs or stops the counter and bit 6 picks single pass or modulo-N; both reset to 0.
`timescale 1ns/1ps
`include "byte_counter_consts.vh"

module eight_bit_transmit_counter #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Register port
  input wire [ADDR_WIDTH-1:0] reg_addr_i,
  input wire [DATA_WIDTH-1:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [DATA_WIDTH-1:0] reg_rdata_o,
  // Output pin and interrupt
  output reg toggle_output_o,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Run states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FIRST = 3'b010;
  localparam [2:0] ST_SECOND = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] byte_down_counter_q;
  reg [7:0] byte_down_counter_d;
  reg toggle_d;
  reg count_enable_bit_q;
  reg count_enable_bit_d;
  reg single_pass_q;
  reg timeout_flag_q;
  reg timeout_flag_d;
  reg [1:0] prescale_select_q;
  reg capture_ie_q;
  reg timeout_ie_q;
  reg init_level_q;
  reg [7:0] low_level_value_q;
  reg [7:0] high_level_value_q;
  reg [7:0] wide_low_value_q;
  reg irq_status_q;
  reg irq_status_d;
  reg irq_mask_q;
  reg [DATA_WIDTH-1:0] rdata_d;
  reg timeout_event;
  reg [7:0] reload_value;

  wire count_tick;
  wire wr_ctrl;
  wire wr_cfg;
  wire wr_low;
  wire wr_high;
  wire wr_wide;
  wire wr_irq_status;
  wire wr_irq_mask;
  wire start_req;
  wire running;
  wire new_level;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_ctrl = reg_write_i & (reg_addr_i == `OFS_COUNTER8_CONTROL);
  assign wr_cfg = reg_write_i & (reg_addr_i == `OFS_SHARED_TIMER_CONFIG);
  assign wr_low = reg_write_i & (reg_addr_i == `OFS_LOW_LEVEL_HOLD);
  assign wr_high = reg_write_i & (reg_addr_i == `OFS_HIGH_LEVEL_HOLD);
  assign wr_wide = reg_write_i & (reg_addr_i == `OFS_WIDE_COUNTER_LOW_HOLD);
  assign wr_irq_status = reg_write_i & (reg_addr_i == `OFS_IRQ_STATUS);
  assign wr_irq_mask = reg_write_i & (reg_addr_i == `OFS_IRQ_MASK);

  // Start only on a 0 to 1 of the enable bit; rewriting 1 while running does not restart
  assign start_req = wr_ctrl & reg_wdata_i[`CTL_ENABLE_BIT] & ~count_enable_bit_q; // RULE_15
  assign running = (state_q != ST_IDLE);
  // Level the output will have after a terminal count toggles it
  assign new_level = ~toggle_output_o;

  ////////////////////////////////////////////////////////////////////////////
  // Count rate from the prescaler
  count_prescaler #(
    .DIV_WIDTH(3)
  ) u_prescaler (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .run_i(running),
    .prescale_select_i(prescale_select_q),
    .tick_o(count_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counting sequence
  // The last step is taken from 1, so a loaded 0 first wraps through FFH: 256 steps.
  // A loaded 1 would give terminal count on the first tick with no count at all.
  always @* begin
    state_d = state_q;
    byte_down_counter_d = byte_down_counter_q;
    toggle_d = toggle_output_o;
    count_enable_bit_d = count_enable_bit_q;
    timeout_event = 1'b0;
    reload_value = new_level ? high_level_value_q : low_level_value_q;
    if (wr_ctrl & ~reg_wdata_i[`CTL_ENABLE_BIT]) begin
      // Stop: output keeps its level, count freezes
      state_d = ST_IDLE;
      count_enable_bit_d = 1'b0; // RULE_15
    end else if (start_req) begin
      count_enable_bit_d = 1'b1;
      state_d = ST_FIRST;
      toggle_d = init_level_q; // RULE_01
      byte_down_counter_d = init_level_q ? high_level_value_q : low_level_value_q; // RULE_02
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_FIRST: begin
          if (count_tick) begin
            if (byte_down_counter_q == `COUNT_LAST) begin // RULE_10
              toggle_d = new_level;
              if (single_pass_q) begin
                // Single pass: halt and flag
                timeout_event = 1'b1; // RULE_03
                byte_down_counter_d = 8'h00;
                state_d = ST_IDLE;
                count_enable_bit_d = 1'b0;
              end else begin
                // Half cycle: no flag, reload by the level just reached
                byte_down_counter_d = reload_value; // RULE_05
                state_d = ST_SECOND;
              end
            end else begin
              byte_down_counter_d = byte_down_counter_q - 8'h01; // RULE_11
            end
          end
        end
        ST_SECOND: begin
          if (count_tick) begin
            if (byte_down_counter_q == `COUNT_LAST) begin
              toggle_d = new_level;
              timeout_event = 1'b1; // RULE_06
              byte_down_counter_d = reload_value; // RULE_07
              state_d = ST_FIRST;
            end else begin
              byte_down_counter_d = byte_down_counter_q - 8'h01; // RULE_11
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Sequence registers
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      byte_down_counter_q <= 8'h00;
      toggle_output_o <= 1'b0;
      count_enable_bit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      byte_down_counter_q <= byte_down_counter_d;
      toggle_output_o <= toggle_d;
      count_enable_bit_q <= count_enable_bit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout flag: a timeout in the same cycle as a clearing write wins
  always @* begin
    timeout_flag_d = timeout_flag_q;
    if (wr_ctrl & reg_wdata_i[`CTL_TIMEOUT_BIT]) begin
      timeout_flag_d = 1'b0; // RULE_14
    end
    if (timeout_event) begin
      timeout_flag_d = 1'b1; // RULE_03
    end
  end

  // Interrupt status: latched only when the timeout interrupt enable is set
  always @* begin
    irq_status_d = irq_status_q;
    if (wr_irq_status & reg_wdata_i[`IRQ_TIMEOUT_BIT]) begin
      irq_status_d = 1'b0;
    end
    if (timeout_event & timeout_ie_q) begin
      irq_status_d = 1'b1; // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, config and hold registers
  // Hold writes never touch the live count; they matter at the next reload only
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      single_pass_q <= 1'b0;
      timeout_flag_q <= 1'b0;
      prescale_select_q <= `PRESCALE_DIV1;
      capture_ie_q <= 1'b0;
      timeout_ie_q <= 1'b0;
      init_level_q <= 1'b0;
      low_level_value_q <= `RST_HOLD;
      high_level_value_q <= `RST_HOLD;
      wide_low_value_q <= `RST_HOLD;
      irq_status_q <= 1'b0;
      irq_mask_q <= 1'b0;
    end else begin
      timeout_flag_q <= timeout_flag_d;
      irq_status_q <= irq_status_d;
      if (wr_ctrl) begin
        single_pass_q <= reg_wdata_i[`CTL_SINGLE_PASS_BIT]; // RULE_15
        prescale_select_q <= reg_wdata_i[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO]; // RULE_13
        capture_ie_q <= reg_wdata_i[`CTL_CAPTURE_IE_BIT]; // RULE_12
        timeout_ie_q <= reg_wdata_i[`CTL_TIMEOUT_IE_BIT]; // RULE_04
      end
      if (wr_cfg) begin
        init_level_q <= reg_wdata_i[`CFG_INIT_LEVEL_BIT];
      end
      // A write colliding with a reload is taken, but the reload sees the old value
      if (wr_low) begin
        low_level_value_q <= reg_wdata_i; // RULE_08 RULE_09
      end
      if (wr_high) begin
        high_level_value_q <= reg_wdata_i; // RULE_08 RULE_09
      end
      if (wr_wide) begin
        wide_low_value_q <= reg_wdata_i;
      end
      if (wr_irq_mask) begin
        irq_mask_q <= reg_wdata_i[`IRQ_TIMEOUT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero
  always @* begin
    rdata_d = {DATA_WIDTH{1'b0}};
    case (reg_addr_i)
      `OFS_COUNTER8_CONTROL: begin
        rdata_d[`CTL_ENABLE_BIT] = count_enable_bit_q;
        rdata_d[`CTL_SINGLE_PASS_BIT] = single_pass_q;
        rdata_d[`CTL_TIMEOUT_BIT] = timeout_flag_q; // RULE_14
        rdata_d[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO] = prescale_select_q;
        rdata_d[`CTL_CAPTURE_IE_BIT] = capture_ie_q;
        rdata_d[`CTL_TIMEOUT_IE_BIT] = timeout_ie_q;
      end
      `OFS_SHARED_TIMER_CONFIG: begin
        rdata_d[`CFG_INIT_LEVEL_BIT] = init_level_q;
      end
      `OFS_LOW_LEVEL_HOLD: begin
        rdata_d[7:0] = low_level_value_q;
      end
      `OFS_HIGH_LEVEL_HOLD: begin
        rdata_d[7:0] = high_level_value_q;
      end
      `OFS_WIDE_COUNTER_LOW_HOLD: begin
        rdata_d[7:0] = wide_low_value_q;
      end
      `OFS_IRQ_STATUS: begin
        rdata_d[`IRQ_TIMEOUT_BIT] = irq_status_q;
      end
      `OFS_IRQ_MASK: begin
        rdata_d[`IRQ_TIMEOUT_BIT] = irq_mask_q;
      end
      `OFS_COUNT_VALUE: begin
        rdata_d[7:0] = byte_down_counter_q;
      end
      default: begin
        rdata_d = {DATA_WIDTH{1'b0}};
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= {DATA_WIDTH{1'b0}};
    end else if (reg_read_i) begin
      reg_rdata_o <= rdata_d;
    end else begin
      reg_rdata_o <= {DATA_WIDTH{1'b0}};
    end
  end

  // Level interrupt from next-state values so it rises with the status bit itself
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_status_d & ((wr_irq_mask) ? reg_wdata_i[`IRQ_TIMEOUT_BIT] : irq_mask_q); // RULE_06
    end
  end

endmodule // eight_bit_transmit_counter

//--- tb/counter_port_chk.sv
// Port checker for the eight-bit transmit counter, bound to the design top.
// Assumes one clock domain and a register read answered one cycle after the strobe.
`timescale 1ns/1ps
module counter_port_chk #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Register port
  input wire [ADDR_WIDTH-1:0] reg_addr_i,
  input wire [DATA_WIDTH-1:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [DATA_WIDTH-1:0] reg_rdata_o,
  // Pin and interrupt
  input wire toggle_output_o,
  input wire irq_o
);
  wire wr_ctl = reg_write_i && reg_addr_i == 8'h00;
  wire wr_mask = reg_write_i && reg_addr_i == 8'h09;
  wire wr_clr = reg_write_i && reg_addr_i == 8'h08 && reg_wdata_i[0];
  reg [7:0] ctl_q;
  reg [7:0] lo_q;
  reg init_q;
  reg stop_q;
  ////////////////////////////////////////
  // Shadows of software writes; stop_q misses a single-pass halt, so it errs towards silence
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_q <= 8'h00;
      lo_q <= 8'h00;
      init_q <= 1'b0;
      stop_q <= 1'b1;
    end else if (reg_write_i) begin
      if (wr_ctl) ctl_q <= reg_wdata_i;
      if (wr_ctl) stop_q <= !reg_wdata_i[7];
      if (reg_addr_i == 8'h04) lo_q <= reg_wdata_i;
      if (reg_addr_i == 8'h01) init_q <= reg_wdata_i[1];
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // Start, stop and flag behaviour
  a_start_level: assert property (wr_ctl && reg_wdata_i[7] && stop_q |=> ##1 toggle_output_o == init_q)
    else $error("toggle output not at initial level after start");
  a_stop_holds: assert property (stop_q && $past(stop_q) && $past(stop_q, 2) |-> $stable(toggle_output_o))
    else $error("toggle output moved while stopped");
  a_flag_clear: assert property (wr_ctl && reg_wdata_i[5] ##1 $stable(toggle_output_o) ##1
    (reg_read_i && reg_addr_i == 8'h00 && $stable(toggle_output_o)) |=> reg_rdata_o[5] == 1'b0)
    else $error("timeout flag survived a write of one");
  // Interrupt output
  a_irq_clear: assert property (wr_clr ##1 $stable(toggle_output_o) ##1 $stable(toggle_output_o) |-> !irq_o)
    else $error("interrupt stayed high after status clear");
  a_irq_cause: assert property ($rose(irq_o) |-> $changed(toggle_output_o) || $past(wr_mask) || $past(wr_mask, 2))
    else $error("interrupt rose without terminal count or mask write");
  a_irq_masked: assert property (wr_mask && !reg_wdata_i[0] ##1 !wr_mask |=> !irq_o)
    else $error("interrupt high with mask cleared");
  // Register readback
  a_hold_readback: assert property (reg_read_i && reg_addr_i == 8'h04 |=> reg_rdata_o == lo_q)
    else $error("low hold readback differs from last write");
  a_ctl_fields: assert property (reg_read_i && reg_addr_i == 8'h00 |=>
    reg_rdata_o[4:2] == ctl_q[4:2] && reg_rdata_o[6] == ctl_q[6])
    else $error("control fields differ from last write");
endmodule // counter_port_chk

bind eight_bit_transmit_counter counter_port_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_counter_port_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .toggle_output_o(toggle_output_o), .irq_o(irq_o));

//--- tb/eight_bit_transmit_counter_tb_top.sv
// Testbench top: table of modulo-N cases, then single pass, interrupts, stop and reset.
// Assumes the load model on the pin; registers reached through the plain register port.
`timescale 1ns/1ps
module eight_bit_transmit_counter_tb_top;
  reg clk_sys_i = 1'b0;
  reg reset_i = 1'b1;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg reg_write_i = 1'b0;
  reg reg_read_i = 1'b0;
  wire [7:0] reg_rdata_o;
  wire toggle_output_o;
  wire irq_o;
  wire [11:0] hi_len;
  wire [11:0] lo_len;
  wire [15:0] edges;
  integer bad_count = 0;
  integer n_checks = 0;
  integer i;
  reg tog_s;
  typedef struct packed {logic [1:0] ps; logic [7:0] lo; logic [7:0] hi; logic init;} row_t;
  row_t rows [0:4] = '{'{2'h0, 8'h02, 8'h03, 1'b0}, '{2'h1, 8'h04, 8'h02, 1'b1},
    '{2'h2, 8'h03, 8'h05, 1'b0}, '{2'h3, 8'h02, 8'h02, 1'b1}, '{2'h0, 8'h00, 8'h05, 1'b0}};
  logic [7:0] addrs [0:8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0f};
  ////////////////////////////////////////
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  eight_bit_transmit_counter u_eight_bit_transmit_counter (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .toggle_output_o(toggle_output_o), .irq_o(irq_o));
  output_load_model u_output_load_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .level_i(toggle_output_o),
    .hi_len_o(hi_len), .lo_len_o(lo_len), .edges_o(edges));
  // Compare, bus cycles and waits; wr, rd and wait_edges start and end in a rising-edge time step
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_read_i <= 1'b0;
    #1;
    tog_s = toggle_output_o;
    chk({4'h0, reg_rdata_o}, {4'h0, exp});
    @(posedge clk_sys_i);
  endtask
  task wait_edges(input integer n);
    integer t;
    integer k;
    t = edges + n;
    k = 0;
    while (edges < t && k < 3000) begin
      @(posedge clk_sys_i);
      k = k + 1;
    end
    if (k >= 3000) chk(edges[11:0], t[11:0]);
  endtask
  // Phase length: a hold of zero gives the full 256 steps
  function [11:0] plen(input [7:0] v, input [1:0] ps);
    plen = (v == 8'h00 ? 12'h100 : {4'h0, v}) << ps;
  endfunction
  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog far beyond the thousand or so cycles the tests need
  initial begin
    #100000;
    bad_count = bad_count + 1;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h01, {6'h00, rows[i].init, 1'b0});
      wr(8'h04, rows[i].lo);
      wr(8'h05, rows[i].hi);
      wr(8'h00, {3'b100, rows[i].ps, 3'b000});
      rd(8'h0a, rows[i].init ? rows[i].hi : rows[i].lo);
      chk({11'h000, tog_s}, {11'h000, rows[i].init});
      wait_edges(4);
      chk(lo_len, plen(rows[i].lo, rows[i].ps));
      chk(hi_len, plen(rows[i].hi, rows[i].ps));
      wr(8'h00, 8'h20);
      $display("row %0d done", i);
    end
    wr(8'h01, 8'h00);
    wr(8'h04, 8'h03);
    wr(8'h09, 8'h01);
    wr(8'h00, 8'hc2);
    wait_edges(1);
    chk({11'h000, irq_o}, 12'h001);
    rd(8'h00, 8'h62);
    chk({11'h000, tog_s}, 12'h001);
    wr(8'h00, 8'h60);
    rd(8'h00, 8'h40);
    wr(8'h08, 8'h01);
    chk({11'h000, irq_o}, 12'h000);
    $display("single pass with interrupt done");
    wr(8'h00, 8'hdc);
    repeat (40) @(posedge clk_sys_i);
    rd(8'h08, 8'h00);
    rd(8'h00, 8'h7c);
    chk({11'h000, irq_o}, 12'h000);
    $display("single pass without interrupt done");
    wr(8'h00, 8'h20);
    wr(8'h04, 8'h02);
    wr(8'h05, 8'h03);
    wr(8'h00, 8'h82);
    wait_edges(2);
    chk({11'h000, irq_o}, 12'h000);
    wr(8'h05, 8'h06);
    wait_edges(1);
    chk({11'h000, irq_o}, 12'h001);
    wait_edges(3);
    chk(hi_len, 12'h006);
    wr(8'h00, 8'h20);
    i = edges;
    repeat (16) @(posedge clk_sys_i);
    chk(edges[11:0], i[11:0]);
    // Status is still set here, so the mask alone must drop and raise the line
    wr(8'h09, 8'h00);
    chk({11'h000, irq_o}, 12'h000);
    wr(8'h09, 8'h01);
    chk({11'h000, irq_o}, 12'h001);
    wr(8'h08, 8'h01);
    $display("modulo interrupt and stop done");
    wr(8'h00, 8'h80);
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    chk({10'h000, toggle_output_o, irq_o}, 12'h000);
    for (i = 0; i < 9; i = i + 1)
      rd(addrs[i], 8'h00);
    $display("reset done");
    finish_test;
  end
endmodule // eight_bit_transmit_counter_tb_top

//--- tb/output_load_model.sv
// Load on the toggle output: measures how many clock cycles each level lasts.
// Assumes the pin changes only at system clock edges; it drives nothing back.
`timescale 1ns/1ps
module output_load_model (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Pin
  input wire level_i,
  // Measurements
  output reg [11:0] hi_len_o,
  output reg [11:0] lo_len_o,
  output reg [15:0] edges_o
);
  reg prev_q;
  reg [11:0] run_q;
  // Latch the length of the level just left; the first phase after a start runs one cycle longer than the rest
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      prev_q <= 1'b0;
      run_q <= 12'h000;
      hi_len_o <= 12'h000;
      lo_len_o <= 12'h000;
      edges_o <= 16'h0000;
    end else begin
      prev_q <= level_i;
      run_q <= (level_i != prev_q) ? 12'h001 : run_q + 12'h001;
      if (level_i != prev_q) edges_o <= edges_o + 16'h0001;
      if (level_i != prev_q && prev_q) hi_len_o <= run_q;
      if (level_i != prev_q && !prev_q) lo_len_o <= run_q;
    end
  end
endmodule // output_load_model
